// ### hdl/vcd_codec.sv
// voice codec digital path: filters, gains, companding, highway serialiser and ahb registers
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "vcd_defines.svh"

module vcd_codec
   import vcd_pkg::*;
#(
   parameter int N_TAPS = 4
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   // ahb-lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // converter side, system clock domain
   input wire logic signed [15:0] ad_sample_i,
   input wire logic ad_valid_i,
   output logic signed [15:0] da_sample_o,
   output logic da_valid_o,
   output logic signed [15:0] dtmf_sample_o,
   output logic dtmf_valid_o,
   // pcm highway, link clock domain
   input wire logic pcm_clk_i,
   input wire logic pcm_fsync_i,
   input wire logic pcm_drx_i,
   output logic pcm_dtx_o,
   output logic pcm_dtx_oe_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // arithmetic helpers

   // clamp a wide result into the signed 16-bit range
   function automatic vcd_sample_t sat16(input logic signed [39:0] v);
      if (v > 40'sd32767) begin
         return 16'sh7fff;
      end else if (v < -40'sd32768) begin
         return 16'sh8000;
      end
      return v[15:0];
   endfunction

   // one first-order high-pass section: y = x - x1 + pole * y1
   function automatic vcd_sample_t hp_step(input vcd_sample_t x, input vcd_sample_t x1,
                                           input vcd_sample_t y1);
      logic signed [39:0] acc;
      acc = 40'(x) - 40'(x1) + ((40'(y1) * 40'(`VCD_HP_POLE)) >>> `VCD_UNITY_SHIFT);
      return sat16(acc);
   endfunction

   // four-tap fir: samples and coefficients packed, tap 0 in the low word
   function automatic vcd_sample_t fir(input logic [16*N_TAPS-1:0] xs,
                                       input logic [16*N_TAPS-1:0] cs);
      logic signed [39:0] acc;
      acc = 40'sd0;
      for (int k = 0; k < N_TAPS; k++) begin
         acc = acc + 40'($signed(xs[16*k+:16])) * 40'($signed(cs[16*k+:16]));
      end
      return sat16(acc >>> `VCD_UNITY_SHIFT);
   endfunction

   // gain multiplier with digital mute
   function automatic vcd_sample_t gain(input vcd_sample_t x, input logic [15:0] g,
                                        input logic mute);
      if (mute) begin
         return 16'sh0000;
      end
      return sat16((40'(x) * 40'($signed(g))) >>> `VCD_UNITY_SHIFT);
   endfunction

   // mu-law encode from 16-bit linear
   function automatic logic [7:0] mu_enc(input vcd_sample_t x);
      logic [15:0] mag;
      logic [2:0] seg;
      logic [3:0] man;
      mag = x[15] ? 16'(-x) : 16'(x);
      if (mag > 16'd32635) begin
         mag = 16'd32635;
      end
      mag = mag + 16'h0084;
      seg = 3'h0;
      for (int i = 0; i < 8; i++) begin
         if (mag[i+7]) begin
            seg = 3'(i);
         end
      end
      man = 4'(mag >> (4'(seg) + 4'h3));
      return ~{x[15], seg, man};
   endfunction

   // mu-law decode to 16-bit linear
   function automatic vcd_sample_t mu_dec(input logic [7:0] c);
      logic [7:0] u;
      logic [15:0] t;
      u = ~c;
      t = {9'h000, u[3:0], 3'h0} + 16'h0084;
      t = t << u[6:4];
      return u[7] ? $signed(16'h0084 - t) : $signed(t - 16'h0084);
   endfunction

   // a-law encode from 16-bit linear
   function automatic logic [7:0] a_enc(input vcd_sample_t x);
      logic [15:0] mag;
      logic [2:0] seg;
      logic [3:0] man;
      mag = x[15] ? 16'(~x) : 16'(x);
      seg = 3'h0;
      for (int i = 0; i < 7; i++) begin
         if (mag >= (16'h0100 << i)) begin
            seg = 3'(i + 1);
         end
      end
      // top segment holds the code range end, larger input clips there
      man = (seg < 3'h2) ? mag[7:4] : 4'(mag >> (4'(seg) + 4'h3));
      return {1'b0, seg, man} ^ (x[15] ? 8'h55 : 8'hd5);
   endfunction

   // a-law decode to 16-bit linear
   function automatic vcd_sample_t a_dec(input logic [7:0] c);
      logic [7:0] a;
      logic [15:0] t;
      a = c ^ 8'h55;
      t = {8'h00, a[3:0], 4'h0};
      unique case (a[6:4])
         3'h0: t = t + 16'h0008;
         3'h1: t = t + 16'h0108;
         default: t = (t + 16'h0108) << (a[6:4] - 3'h1);
      endcase
      return a[7] ? $signed(t) : $signed(16'(-t));
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // register storage

   logic [`VCD_CTRL_W-1:0] ctrl; // digital_control_word
   logic [15:0] transmit_level_coef; // transmit gain
   logic [15:0] receive_level_coef; // receive gain
   logic [15:0] transmit_tap_coefs [N_TAPS];
   logic [15:0] receive_tap_coefs [N_TAPS];
   logic [16*N_TAPS-1:0] tx_cs; // packed views for the fir
   logic [16*N_TAPS-1:0] rx_cs;
   logic wr_pend; // write data phase pending
   logic [11:0] wr_addr; // its captured offset
   vcd_sample_t tx_last; // last transmit linear sample, readable
   vcd_sample_t rx_last; // last receive linear sample, readable

   wire logic tx_mute = ctrl[`VCD_BIT_TX_MUTE];
   wire logic rx_mute = ctrl[`VCD_BIT_RX_MUTE];
   wire logic bypass = ctrl[`VCD_BIT_BYPASS]; // companding_bypass
   wire vcd_law_e law = ctrl[`VCD_BIT_ALAW] ? VCD_A_LAW : VCD_MU_LAW;
   wire logic dtmf_en = ctrl[`VCD_BIT_DTMF_EN];

   // ce low stalls the bus, since state is frozen and a transfer would be lost
   assign hreadyout_o = ce_i;
   assign hresp_o = 1'b0;

   // pack coefficient arrays
   genvar gk;
   generate
      for (gk = 0; gk < N_TAPS; gk++) begin : g_pack
         assign tx_cs[16*gk+:16] = transmit_tap_coefs[gk];
         assign rx_cs[16*gk+:16] = receive_tap_coefs[gk];
      end
   endgenerate

   // read value of one offset; unmapped offsets read zero
   function automatic logic [31:0] rd_mux(input logic [11:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      if (a == `VCD_OFF_CTRL) begin
         r = 32'(ctrl);
      end else if (a == `VCD_OFF_TX_GAIN) begin
         r = {16'h0000, transmit_level_coef};
      end else if (a == `VCD_OFF_RX_GAIN) begin
         r = {16'h0000, receive_level_coef};
      end else if (a == `VCD_OFF_STATUS) begin
         r = {rx_last, tx_last};
      end
      for (int k = 0; k < N_TAPS; k++) begin
         if (a == `VCD_OFF_TX_TAP0 + 12'(4 * k)) begin
            r = {16'h0000, transmit_tap_coefs[k]};
         end
         if (a == `VCD_OFF_RX_TAP0 + 12'(4 * k)) begin
            r = {16'h0000, receive_tap_coefs[k]};
         end
      end
      return r;
   endfunction

   // address phase: remember writes, answer reads from a flop in the data phase
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wr_pend <= 1'b0;
         wr_addr <= 12'h000;
         hrdata_o <= 32'h0000_0000;
      end else if (ce_i && hready_i) begin
         wr_pend <= hsel_i && htrans_i[1] && hwrite_i;
         wr_addr <= haddr_i[11:0];
         if (hsel_i && htrans_i[1] && !hwrite_i) begin
            hrdata_o <= rd_mux(haddr_i[11:0]);
         end
      end
   end

   // data phase write of the control and coefficient registers
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ctrl <= `VCD_RST_CTRL;
         transmit_level_coef <= `VCD_RST_GAIN;
         receive_level_coef <= `VCD_RST_GAIN;
         for (int k = 0; k < N_TAPS; k++) begin
            transmit_tap_coefs[k] <= (k == 0) ? `VCD_RST_TAP0 : `VCD_RST_TAPN;
            receive_tap_coefs[k] <= (k == 0) ? `VCD_RST_TAP0 : `VCD_RST_TAPN;
         end
      end else if (ce_i && wr_pend) begin
         if (wr_addr == `VCD_OFF_CTRL) begin
            ctrl <= hwdata_i[`VCD_CTRL_W-1:0];
         end
         // each direction has its own gain word
         if (wr_addr == `VCD_OFF_TX_GAIN) begin
            transmit_level_coef <= hwdata_i[15:0];
         end
         if (wr_addr == `VCD_OFF_RX_GAIN) begin
            receive_level_coef <= hwdata_i[15:0];
         end
         for (int k = 0; k < N_TAPS; k++) begin
            if (wr_addr == `VCD_OFF_TX_TAP0 + 12'(4 * k)) begin
               transmit_tap_coefs[k] <= hwdata_i[15:0];
            end
            if (wr_addr == `VCD_OFF_RX_TAP0 + 12'(4 * k)) begin
               receive_tap_coefs[k] <= hwdata_i[15:0];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // transmit path

   logic [3:0] tx_vld; // stage valids
   vcd_sample_t hp_x1a, hp_y1a, hp_x1b, hp_y1b; // high-pass section state
   vcd_sample_t hp_out; // after both sections
   logic [16*N_TAPS-1:0] tx_line; // equalizer delay line, newest in the low word
   vcd_sample_t tx_eq; // equalizer output
   logic [15:0] tx_word; // word offered to the highway, held between samples
   logic tx_tgl; // flips once per new word

   wire vcd_sample_t hp_a = hp_step(ad_sample_i, hp_x1a, hp_y1a);
   wire vcd_sample_t hp_b = hp_step(hp_y1a, hp_x1b, hp_y1b);

   // stage 0: the band above 3.4 kHz was already removed by the decimator
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         tx_vld <= 4'h0;
         hp_x1a <= 16'sh0000;
         hp_y1a <= 16'sh0000;
         hp_x1b <= 16'sh0000;
         hp_y1b <= 16'sh0000;
         hp_out <= 16'sh0000;
      end else if (ce_i) begin
         tx_vld <= {tx_vld[2:0], ad_valid_i};
         if (ad_valid_i) begin
            // two cascaded sections, the second lags one sample for short logic
            hp_x1a <= ad_sample_i;
            hp_y1a <= hp_a;
            hp_x1b <= hp_y1a;
            hp_y1b <= hp_b;
            hp_out <= hp_b;
         end
      end
   end

   // stage 1: equalizer over the last four high-pass samples
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         tx_line <= '0;
         tx_eq <= 16'sh0000;
      end else if (ce_i && tx_vld[0]) begin
         tx_line <= {tx_line[16*N_TAPS-17:0], hp_out};
         tx_eq <= fir({tx_line[16*N_TAPS-17:0], hp_out}, tx_cs);
      end
   end

   // stage 2: gain and mute; the linear result also feeds the digit decoder
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         tx_last <= 16'sh0000;
         dtmf_sample_o <= 16'sh0000;
         dtmf_valid_o <= 1'b0;
      end else if (ce_i) begin
         dtmf_valid_o <= 1'b0;
         if (tx_vld[1]) begin
            tx_last <= gain(tx_eq, transmit_level_coef, tx_mute);
            if (dtmf_en) begin
               dtmf_sample_o <= gain(tx_eq, transmit_level_coef, tx_mute);
               dtmf_valid_o <= 1'b1;
            end
         end
      end
   end

   // stage 3: compression is the last step, then the word is offered to the link
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         tx_word <= 16'h0000;
         tx_tgl <= 1'b0;
      end else if (ce_i && tx_vld[2]) begin
         if (bypass) begin
            tx_word <= tx_last;
         end else if (law == VCD_A_LAW) begin
            tx_word <= {a_enc(tx_last), 8'h00};
         end else begin
            tx_word <= {mu_enc(tx_last), 8'h00};
         end
         tx_tgl <= ~tx_tgl;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // receive path

   logic rx_s1, rx_s2, rx_seen; // toggle synchroniser from the link
   logic [15:0] rx_cap; // captured highway word
   logic [2:0] rx_vld; // stage valids
   vcd_sample_t rx_lin; // expanded or assembled sample
   logic [16*N_TAPS-1:0] rx_line; // receive equalizer delay line
   vcd_sample_t rx_eq;
   logic [15:0] rx_word_l; // link domain word, stable while its toggle settles
   logic rx_tgl_l;

   // catch a new receive word once its toggle has crossed
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rx_s1 <= 1'b0;
         rx_s2 <= 1'b0;
         rx_seen <= 1'b0;
         rx_cap <= 16'h0000;
         rx_vld <= 3'h0;
      end else if (ce_i) begin
         rx_s1 <= rx_tgl_l;
         rx_s2 <= rx_s1;
         rx_seen <= rx_s2;
         rx_vld <= {rx_vld[1:0], rx_s2 != rx_seen};
         if (rx_s2 != rx_seen) begin
            rx_cap <= rx_word_l;
         end
      end
   end

   // expansion, equalizer and gain, one stage each
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rx_lin <= 16'sh0000;
         rx_line <= '0;
         rx_eq <= 16'sh0000;
         rx_last <= 16'sh0000;
         da_sample_o <= 16'sh0000;
         da_valid_o <= 1'b0;
      end else if (ce_i) begin
         da_valid_o <= rx_vld[2];
         if (rx_vld[0]) begin
            if (bypass) begin
               rx_lin <= rx_cap;
            end else if (law == VCD_A_LAW) begin
               rx_lin <= a_dec(rx_cap[7:0]);
            end else begin
               rx_lin <= mu_dec(rx_cap[7:0]);
            end
         end
         if (rx_vld[1]) begin
            rx_line <= {rx_line[16*N_TAPS-17:0], rx_lin};
            rx_eq <= fir({rx_line[16*N_TAPS-17:0], rx_lin}, rx_cs);
         end
         if (rx_vld[2]) begin
            rx_last <= gain(rx_eq, receive_level_coef, rx_mute);
            da_sample_o <= gain(rx_eq, receive_level_coef, rx_mute);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // highway side, pcm clock domain; the clock may stop between frames

   logic lrst_s1, lrst; // reset carried into the link domain
   logic byp_s1, byp_l; // mode level carried into the link domain
   logic tx_s1, tx_s2, tx_seen; // toggle synchroniser from the core
   logic [15:0] tx_pend; // next word to send
   logic [15:0] tx_sh; // transmit shift register
   logic [15:0] rx_sh; // receive shift register
   logic [3:0] bcnt; // bit within the frame
   logic active; // frame in progress

   wire logic [3:0] last_bit = byp_l ? `VCD_LAST_BIT_LIN : `VCD_LAST_BIT_COMP;

   // level synchronisers and the transmit word catch
   always_ff @(posedge pcm_clk_i) begin
      lrst_s1 <= srst_i;
      lrst <= lrst_s1;
      byp_s1 <= bypass;
      byp_l <= byp_s1;
      if (lrst) begin
         tx_s1 <= 1'b0;
         tx_s2 <= 1'b0;
         tx_seen <= 1'b0;
         tx_pend <= 16'h0000;
      end else begin
         tx_s1 <= tx_tgl;
         tx_s2 <= tx_s1;
         tx_seen <= tx_s2;
         if (tx_s2 != tx_seen) begin
            tx_pend <= tx_word;
         end
      end
   end

   // frame sequencer: the frame sync starts one or two slots of eight bits
   always_ff @(posedge pcm_clk_i) begin
      if (lrst) begin
         active <= 1'b0;
         bcnt <= 4'h0;
         tx_sh <= 16'h0000;
         rx_sh <= 16'h0000;
         rx_word_l <= 16'h0000;
         rx_tgl_l <= 1'b0;
      end else if (pcm_fsync_i) begin
         active <= 1'b1;
         bcnt <= 4'h0;
         tx_sh <= tx_pend; // msb goes out first
      end else if (active) begin
         rx_sh <= {rx_sh[14:0], pcm_drx_i};
         tx_sh <= {tx_sh[14:0], 1'b0};
         bcnt <= bcnt + 4'h1;
         if (bcnt == last_bit) begin
            // whole slot pair or single slot received
            active <= 1'b0;
            rx_word_l <= byp_l ? {rx_sh[14:0], pcm_drx_i} : {8'h00, rx_sh[6:0], pcm_drx_i};
            rx_tgl_l <= ~rx_tgl_l;
         end
      end
   end

   // highway driver, enabled only during the owned slots
   assign pcm_dtx_o = tx_sh[15];
   assign pcm_dtx_oe_o = active;

   // unused bus inputs: only whole-word transfers exist on this bus
   wire logic unused_ok = &{1'b0, hsize_i, haddr_i[31:12]};

endmodule

// ### hdl/vcd_defines.svh
// register offsets, field positions, reset values and link counts of the voice codec path
`ifndef VCD_DEFINES_SVH
`define VCD_DEFINES_SVH

// register byte offsets inside the slave window
`define VCD_OFF_CTRL 12'h000
`define VCD_OFF_TX_GAIN 12'h004
`define VCD_OFF_RX_GAIN 12'h008
`define VCD_OFF_TX_TAP0 12'h010
`define VCD_OFF_RX_TAP0 12'h020
`define VCD_OFF_STATUS 12'h030

// fields of the digital control word
`define VCD_BIT_TX_MUTE 0
`define VCD_BIT_RX_MUTE 1
`define VCD_BIT_BYPASS 2
`define VCD_BIT_ALAW 3
`define VCD_BIT_DTMF_EN 4
`define VCD_CTRL_W 5

// reset values
`define VCD_RST_CTRL 5'h00
`define VCD_RST_GAIN 16'h4000
`define VCD_RST_TAP0 16'h4000
`define VCD_RST_TAPN 16'h0000

// fixed point: 16384 is unity
`define VCD_UNITY_SHIFT 14
// pole of each high-pass section, 0.949 in the same scale
`define VCD_HP_POLE 17'sh03cbc

// index of the last bit of a highway frame in each mode, one less than its bit count
`define VCD_LAST_BIT_COMP 4'h7
`define VCD_LAST_BIT_LIN 4'hf

`endif

// ### hdl/vcd_pkg.sv
// shared types of the voice codec digital path
package vcd_pkg;
   // one linear voice sample
   typedef logic signed [15:0] vcd_sample_t;
   // companding law
   typedef enum logic {VCD_MU_LAW, VCD_A_LAW} vcd_law_e;
endpackage

// ### verif/vcd_codec_props.sv
// checker of the voice codec path, bound to the top ports
`timescale 1ns/100ps
module vcd_codec_props (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic ad_valid_i,
   input wire logic da_valid_o,
   input wire logic signed [15:0] dtmf_sample_o,
   input wire logic dtmf_valid_o,
   input wire logic pcm_clk_i,
   input wire logic pcm_fsync_i,
   input wire logic pcm_dtx_oe_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // read address phase aimed past the status word
   logic rd_unmapped;
   assign rd_unmapped = hsel_i && htrans_i[1] && !hwrite_i && hready_i && ce_i
      && (haddr_i[11:0] > 12'h030);
   ////////////////////////////////////////////////////////////////////////////////
   ready_follows_ce_a: assert property (@(posedge clk_i) disable iff (srst_i)
      hreadyout_o == ce_i && !hresp_o) else $error("bus ready or response wrong");
   unmapped_read_zero_a: assert property (@(posedge clk_i) disable iff (srst_i)
      rd_unmapped |=> hrdata_o == 32'h0) else $error("unmapped read not zero");
   reset_quiet_a: assert property (@(posedge clk_i)
      srst_i |=> hrdata_o == 32'h0 && !da_valid_o && !dtmf_valid_o) else $error("live in reset");
   tone_latency_a: assert property (@(posedge clk_i) disable iff (srst_i)
      dtmf_valid_o |-> $past(ad_valid_i, 3)) else $error("tone sample latency wrong");
   tone_pulse_a: assert property (@(posedge clk_i) disable iff (srst_i)
      dtmf_valid_o |=> !dtmf_valid_o) else $error("tone valid longer than one cycle");
   tone_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
      $fell(dtmf_valid_o) |-> $stable(dtmf_sample_o)) else $error("tone sample not held");
   dac_pulse_a: assert property (@(posedge clk_i) disable iff (srst_i)
      da_valid_o |=> !da_valid_o) else $error("converter valid longer than one cycle");
   slot_start_a: assert property (@(posedge pcm_clk_i) disable iff (srst_i)
      $rose(pcm_dtx_oe_o) |-> $past(pcm_fsync_i)) else $error("drive without frame sync");
   slot_length_a: assert property (@(posedge pcm_clk_i) disable iff (srst_i)
      $rose(pcm_dtx_oe_o) |-> pcm_dtx_oe_o[*8] ##1
      (!pcm_dtx_oe_o or (pcm_dtx_oe_o[*8] ##1 !pcm_dtx_oe_o))) else $error("slot length wrong");
endmodule
bind vcd_codec vcd_codec_props u_vcd_codec_props (.clk_i, .srst_i, .ce_i, .hsel_i, .haddr_i,
   .htrans_i, .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .ad_valid_i,
   .da_valid_o, .dtmf_sample_o, .dtmf_valid_o, .pcm_clk_i, .pcm_fsync_i, .pcm_dtx_oe_o);

// ### verif/vcd_highway_model.sv
// highway time-slot master: frame sync, receive bits out, transmit bits captured
`timescale 1ns/100ps
module vcd_highway_model (
   input wire logic pcm_clk_i,
   input wire logic pcm_dtx_i,
   output logic pcm_fsync_o,
   output logic pcm_drx_o
);
   // idle levels; the data line is left at the inverse of its last bit between frames
   initial begin
      pcm_fsync_o = 1'b0;
      pcm_drx_o = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // one frame of nb bits each way, msb first, changed just after a rising edge
   task automatic frame(input logic [15:0] rxw, input int nb, output logic [15:0] txw);
      txw = 16'h0000;
      @(posedge pcm_clk_i);
      pcm_fsync_o <= 1'b1;
      @(posedge pcm_clk_i);
      pcm_fsync_o <= 1'b0;
      pcm_drx_o <= rxw[nb-1];
      for (int i = 1; i <= nb; i++) begin
         @(posedge pcm_clk_i);
         txw = {txw[14:0], pcm_dtx_i};
         pcm_drx_o <= (i < nb) ? rxw[nb-1-i] : ~rxw[0];
      end
   endtask
endmodule

// ### verif/voice_codec_digital_path_bench.sv
// self-checking bench of the voice codec path
`timescale 1ns/100ps
`include "vcd_defines.svh"
`define CHK(a_, b_) begin samples_checked++; if ((a_) !== (b_)) begin errors++; \
   $display("ERROR t=%0t got %h exp %h", $time, a_, b_); end end
module voice_codec_digital_path_bench;
   logic clk_i = 1'b0;
   logic pcm_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic ce_i = 1'b1;
   logic hsel_i = 1'b0;
   logic hwrite_i = 1'b0;
   logic [1:0] htrans_i = 2'h0;
   logic [31:0] haddr_i = 32'h0;
   logic [31:0] hwdata_i = 32'h0;
   logic signed [15:0] ad_sample_i = 16'sh0;
   logic ad_valid_i = 1'b0;
   logic [31:0] hrdata_o;
   logic hreadyout_o, hresp_o, da_valid_o, dtmf_valid_o, pcm_dtx_o, pcm_dtx_oe_o;
   logic pcm_fsync_i, pcm_drx_i;
   logic signed [15:0] da_sample_o, dtmf_sample_o;
   int errors = 0;
   int samples_checked = 0;
   logic [31:0] rd; // last bus read data
   logic [15:0] txw; // last word seen on the highway
   always #5 clk_i = ~clk_i;
   // link clock, phase unrelated to the core clock
   initial begin
      #33;
      forever #80 pcm_clk_i = ~pcm_clk_i;
   end
   vcd_codec u_vcd_codec (.clk_i, .srst_i, .ce_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
      .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
      .ad_sample_i, .ad_valid_i, .da_sample_o, .da_valid_o, .dtmf_sample_o, .dtmf_valid_o,
      .pcm_clk_i, .pcm_fsync_i, .pcm_drx_i, .pcm_dtx_o, .pcm_dtx_oe_o);
   vcd_highway_model u_vcd_highway_model (.pcm_clk_i, .pcm_dtx_i(pcm_dtx_o),
      .pcm_fsync_o(pcm_fsync_i), .pcm_drx_o(pcm_drx_i));
   ////////////////////////////////////////////////////////////////////////////////
   // single word transfer; each phase held until ready is sampled high
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      hsel_i <= 1'b1;
      haddr_i <= {20'h0, a};
      htrans_i <= 2'h2;
      hwrite_i <= wr;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1 && ++n < 100);
      htrans_i <= 2'h0;
      hsel_i <= 1'b0;
      hwdata_i <= d;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1 && ++n < 100);
      rd = hrdata_o;
      if (n >= 100) errors++;
   endtask
   // one highway frame, then the converter word that it yields
   task automatic rx(input logic [15:0] w, input int nb, output logic [15:0] got);
      int n;
      n = 0;
      u_vcd_highway_model.frame(w, nb, txw);
      do @(posedge clk_i); while (da_valid_o !== 1'b1 && ++n < 100);
      got = da_sample_o;
   endtask
   // one converter sample in; tone output watched, then time to reach the link
   task automatic tx(input logic [15:0] x, output logic seen, output logic [15:0] s);
      seen = 1'b0;
      s = 16'h0;
      @(posedge clk_i);
      ad_sample_i <= x;
      ad_valid_i <= 1'b1;
      @(posedge clk_i);
      ad_valid_i <= 1'b0;
      repeat (6) begin
         @(posedge clk_i);
         if (dtmf_valid_o === 1'b1) begin
            seen = 1'b1;
            s = dtmf_sample_o;
         end
      end
      repeat (150) @(posedge clk_i);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // reset values, an unmapped place, a write stalled by the clock enable
   task automatic regs_reset();
      logic [11:0] adr [6] = '{12'h000, 12'h004, 12'h008, 12'h010, 12'h014, 12'h020};
      logic [31:0] val [6] = '{32'h0, 32'h4000, 32'h4000, 32'h4000, 32'h0, 32'h4000};
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, adr[i], 32'h0);
         `CHK(rd, val[i])
      end
      bus(1'b1, 12'h034, 32'h5a5a);
      bus(1'b0, 12'h034, 32'h0);
      `CHK(rd, 32'h0)
      @(posedge clk_i);
      ce_i <= 1'b0;
      fork
         bus(1'b1, `VCD_OFF_TX_GAIN, 32'h1234);
         begin
            repeat (4) @(posedge clk_i);
            ce_i <= 1'b1;
         end
      join
      bus(1'b0, `VCD_OFF_TX_GAIN, 32'h0);
      `CHK(rd, 32'h1234)
      bus(1'b0, `VCD_OFF_RX_GAIN, 32'h0);
      `CHK(rd, 32'h4000)
   endtask
   // receive gain over linear highway words, transmit gain set to mute meanwhile
   task automatic rx_gain();
      logic [15:0] g;
      logic [15:0] gn [5] = '{16'h2000, 16'h0000, 16'h7fff, 16'h7fff, 16'h4000};
      logic [15:0] wd [5] = '{16'h1234, 16'h1234, 16'h6000, 16'ha000, 16'hedcb};
      logic [15:0] ex [5] = '{16'h091a, 16'h0000, 16'h7fff, 16'h8000, 16'hedcb};
      bus(1'b1, `VCD_OFF_CTRL, 32'h4);
      bus(1'b1, `VCD_OFF_TX_GAIN, 32'h0);
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, `VCD_OFF_RX_GAIN, {16'h0, gn[i]});
         rx(wd[i], 16, g);
         `CHK(g, ex[i])
      end
      bus(1'b1, `VCD_OFF_CTRL, 32'h6);
      rx(16'h1234, 16, g);
      `CHK(g, 16'h0000)
      bus(1'b0, `VCD_OFF_RX_GAIN, 32'h0);
      `CHK(rd, 32'h4000)
      bus(1'b1, `VCD_OFF_TX_GAIN, 32'h4000);
   endtask
   // second receive tap at half weight, then a sum that must clip
   task automatic rx_eq();
      logic [15:0] g;
      bus(1'b1, `VCD_OFF_CTRL, 32'h4);
      bus(1'b1, `VCD_OFF_RX_TAP0 + 12'h4, 32'h2000);
      rx(16'h0200, 16, g);
      rx(16'h0400, 16, g);
      `CHK(g, 16'h0500)
      rx(16'h7000, 16, g);
      rx(16'h7000, 16, g);
      `CHK(g, 16'h7fff)
      bus(1'b1, `VCD_OFF_RX_TAP0 + 12'h4, 32'h0);
   endtask
   // expansion of both laws: mu-law at the largest magnitudes, a-law at the smallest
   task automatic rx_expand();
      logic [15:0] g;
      logic [7:0] cd [4] = '{8'h80, 8'h00, 8'hd5, 8'h55};
      logic [31:0] ct [4] = '{32'h0, 32'h0, 32'h8, 32'h8};
      logic [15:0] ex [4] = '{16'h7d7c, 16'h8284, 16'h0008, 16'hfff8};
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, `VCD_OFF_CTRL, ct[i]);
         rx({8'h0, cd[i]}, 8, g);
         `CHK(g, ex[i])
      end
   endtask
   // transmit codes of silence in each mode, tone output gated and fed
   task automatic tx_path();
      logic sn;
      logic [15:0] s;
      logic [31:0] ct [3] = '{32'h11, 32'h19, 32'h15};
      logic [15:0] ex [3] = '{16'h00ff, 16'h00d5, 16'h0000};
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, `VCD_OFF_CTRL, ct[i]);
         tx(16'h4000, sn, s);
         `CHK({sn, s}, 17'h10000)
         u_vcd_highway_model.frame(16'h0, (i == 2) ? 16 : 8, txw);
         `CHK(txw & ((i == 2) ? 16'hffff : 16'h00ff), ex[i])
      end
      bus(1'b1, `VCD_OFF_CTRL, 32'h0);
      bus(1'b1, `VCD_OFF_TX_GAIN, 32'h0);
      tx(16'h4000, sn, s);
      `CHK(sn, 1'b0)
      u_vcd_highway_model.frame(16'h0, 8, txw);
      `CHK(txw[7:0], 8'hff)
      bus(1'b1, `VCD_OFF_CTRL, 32'h10);
      bus(1'b1, `VCD_OFF_TX_GAIN, 32'h4000);
      // the second high-pass section lags one sample, so the step shows a sample late
      tx(16'hc000, sn, s);
      tx(16'hc000, sn, s);
      `CHK({sn, s[15]}, 2'h3)
      bus(1'b1, `VCD_OFF_CTRL, 32'h0);
      bus(1'b1, `VCD_OFF_TX_GAIN, 32'h7fff);
      tx(16'h7fff, sn, s);
      u_vcd_highway_model.frame(16'h0, 8, txw);
      `CHK(txw[7:0], 8'h00)
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("comparisons %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // reset must span several link edges so the link side is cleared too
   initial begin
      repeat (4) @(posedge pcm_clk_i);
      @(posedge clk_i);
      srst_i <= 1'b0;
      regs_reset();
      rx_gain();
      rx_eq();
      rx_expand();
      tx_path();
      stop_test();
   end
   // whole run needs well under this span
   initial begin
      #300000;
      errors++;
      stop_test();
   end
endmodule
